/* design/cdr_pkg.sv */
// Package for the character display data access and reset block
package cdr_pkg;
  localparam int DDR_DEPTH = 128;
  localparam int CGR_DEPTH = 64;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam logic INC_RESET = 1'b1;
  localparam logic SHIFT_RESET = 1'b0;
  localparam logic WIDTH8_RESET = 1'b1;
  localparam logic [1:0] BRIGHT_RESET = 2'h0;
  localparam logic [7:0] FN_SET_MASK = 8'he0;
  localparam logic [7:0] FN_SET_CODE = 8'h20;
  localparam int FN_WIDTH_BIT = 4;
  localparam int FN_LINES_BIT = 3;
  localparam int ENTRY_INC_BIT = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int ONOFF_DISP_BIT = 2;
  localparam int ONOFF_CUR_BIT = 1;
  localparam int ONOFF_BLINK_BIT = 0;
  localparam int CG_SEL_BIT = 6;
  localparam int DD_SEL_BIT = 7;
  localparam int FN_BRIGHT_MSB = 1;
  localparam int FN_BRIGHT_LSB = 0;
  localparam logic [7:0] CLEAR_CODE = 8'h01;
  localparam logic [7:0] HOME_MASK = 8'hfe;
  localparam logic [7:0] HOME_CODE = 8'h02;
  localparam logic [7:0] ENTRY_MASK = 8'hfc;
  localparam logic [7:0] ENTRY_CODE = 8'h04;
  localparam logic [7:0] ONOFF_MASK = 8'hf8;
  localparam logic [7:0] ONOFF_CODE = 8'h08;
  localparam logic [6:0] OFFSET_RESET = 7'h00;
  localparam logic DISPLAY_ON_RESET = 1'h0;
  localparam logic CURSOR_ON_RESET = 1'h0;
  localparam logic BLINK_RESET = 1'h0;
  localparam logic CG_SEL_RESET = 1'h0;

  typedef enum logic [2:0] {
    CDR_BUS_STROBE = 3'h1,
    CDR_BUS_ENABLE = 3'h2,
    CDR_BUS_SERIAL = 3'h4
  } cdr_bus_mode_e;

  // One host access as seen by the core
  typedef struct packed {
    logic cmd_data_select;
    logic is_read;
    logic [7:0] data;
  } cdr_access_s;

  // Mode bits held by the core
  typedef struct packed {
    logic inc_select;
    logic shift_enable;
    logic display_on;
    logic cursor_on;
    logic blink_enable;
    logic bus_width_select;
    logic two_lines;
    logic [1:0] brightness_field;
  } cdr_mode_s;
endpackage

/* design/cdr_core.sv */
// Instruction executor of a 16x2 character display controller
//
// Function
// - Counter read returns 7-bit counter on bits 6..0, busy bit 7 always zero.
// - Counter read changes no RAM and not the counter.
// - Never busy: writes accepted back to back; a read waits while the two-entry read buffer is full.
// - Data write stores the byte in RAM chosen by last address set.
// - Each data access steps counter by increment bit; display RAM writes shift display if enabled.
// - Data read returns the byte from RAM chosen by last address set.
// - Reset fills display RAM with space code.
// - Reset points counter at display address zero, display unshifted.
// - Reset sets increment bit, clears shift enable.
// - Reset clears display on, cursor on and blink.
// - Reset selects 8-bit bus, two lines per parameter, full brightness.
// - Straps pick serial or parallel, strobe or enable style, reset pin use.
// - Increment shifts left, decrement shifts right, once per display write.
// - Address set loads 6-bit pattern or 7-bit display address, selects RAM.
// - Brightness field 00,01,10,11 gives 100,75,50,25 percent.
`timescale 1ns/1ps
module cdr_core #(
  parameter bit MULTI_LINE = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic strap_serial_a_in,
  input wire logic strap_serial_b_in,
  input wire logic strap_enable_style_bus_in,
  input wire logic strap_strobe_style_bus_in,
  input wire logic strap_reset_pin_enable_in,
  input wire logic ext_reset_n_in,
  input wire logic acc_valid_in,
  output logic acc_ready_out,
  input wire cdr_pkg::cdr_access_s acc_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [7:0] rd_data_out,
  output cdr_pkg::cdr_mode_s mode_out,
  output cdr_pkg::cdr_bus_mode_e bus_mode_out,
  output logic [6:0] disp_offset_out
);

  // Strap and reset-pin inputs come from outside the clock domain
  logic [1:0] serial_a_sync_q;
  logic [1:0] serial_b_sync_q;
  logic [1:0] enable_style_sync_q;
  logic [1:0] strobe_style_sync_q;
  logic [1:0] reset_pin_en_sync_q;
  logic [1:0] ext_reset_n_sync_q;
  logic serial_mode_w;
  logic ext_reset_w;
  logic core_rst_w;

  // Access decode
  logic acc_fire_w;
  logic ctr_read_w;
  logic instr_w;
  logic data_wr_w;
  logic data_rd_w;
  logic dd_set_w;
  logic cg_set_w;
  logic fn_set_w;
  logic onoff_w;
  logic entry_w;
  logic home_w;
  logic clear_w;
  logic ac_step_w;

  // Core state
  logic [6:0] ac_q;
  logic [6:0] ac_stepped_w;
  logic cg_sel_q;
  logic [6:0] offset_q;
  cdr_pkg::cdr_mode_s mode_q;
  cdr_pkg::cdr_bus_mode_e bus_mode_q;
  logic [7:0] ddr_q [cdr_pkg::DDR_DEPTH];
  logic [7:0] cgr_q [cdr_pkg::CGR_DEPTH];
  logic [7:0] rd_value_w;

  // Two-entry read-data buffer
  logic push_w;
  logic pop_w;
  logic [1:0] rd_cnt_q;
  logic [7:0] rd_head_q;
  logic [7:0] rd_spare_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      serial_a_sync_q <= 2'h0;
      serial_b_sync_q <= 2'h0;
      enable_style_sync_q <= 2'h0;
      strobe_style_sync_q <= 2'h0;
      reset_pin_en_sync_q <= 2'h0;
      ext_reset_n_sync_q <= 2'h3;
    end
    else
    begin
      serial_a_sync_q <= {serial_a_sync_q[0], strap_serial_a_in};
      serial_b_sync_q <= {serial_b_sync_q[0], strap_serial_b_in};
      enable_style_sync_q <= {enable_style_sync_q[0], strap_enable_style_bus_in};
      strobe_style_sync_q <= {strobe_style_sync_q[0], strap_strobe_style_bus_in};
      reset_pin_en_sync_q <= {reset_pin_en_sync_q[0], strap_reset_pin_enable_in};
      ext_reset_n_sync_q <= {ext_reset_n_sync_q[0], ext_reset_n_in};
    end
  end

  // Serial needs both serial straps; the reset pin exists only in parallel mode
  assign serial_mode_w = serial_a_sync_q[1] && serial_b_sync_q[1];
  assign ext_reset_w = !serial_mode_w && reset_pin_en_sync_q[1] && !ext_reset_n_sync_q[1];
  assign core_rst_w = !rst_n_in || ext_reset_w;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      bus_mode_q <= cdr_pkg::CDR_BUS_STROBE;
    else if (serial_mode_w)
      bus_mode_q <= cdr_pkg::CDR_BUS_SERIAL;
    else if (enable_style_sync_q[1] && !strobe_style_sync_q[1])
      bus_mode_q <= cdr_pkg::CDR_BUS_ENABLE;
    else
      bus_mode_q <= cdr_pkg::CDR_BUS_STROBE;
  end

  // Writes are never held off; a read waits only for room in the buffer
  assign acc_ready_out = !acc_in.is_read || (rd_cnt_q != 2'h2);
  assign acc_fire_w = acc_valid_in && acc_ready_out;
  assign ctr_read_w = acc_fire_w && !acc_in.cmd_data_select && acc_in.is_read;
  assign instr_w = acc_fire_w && !acc_in.cmd_data_select && !acc_in.is_read;
  assign data_wr_w = acc_fire_w && acc_in.cmd_data_select && !acc_in.is_read;
  assign data_rd_w = acc_fire_w && acc_in.cmd_data_select && acc_in.is_read;
  assign dd_set_w = instr_w && acc_in.data[cdr_pkg::DD_SEL_BIT];
  assign cg_set_w = instr_w && !acc_in.data[cdr_pkg::DD_SEL_BIT]
    && acc_in.data[cdr_pkg::CG_SEL_BIT];
  assign fn_set_w = instr_w && ((acc_in.data & cdr_pkg::FN_SET_MASK) == cdr_pkg::FN_SET_CODE);
  assign onoff_w = instr_w && ((acc_in.data & cdr_pkg::ONOFF_MASK) == cdr_pkg::ONOFF_CODE);
  assign entry_w = instr_w && ((acc_in.data & cdr_pkg::ENTRY_MASK) == cdr_pkg::ENTRY_CODE);
  assign home_w = instr_w && ((acc_in.data & cdr_pkg::HOME_MASK) == cdr_pkg::HOME_CODE);
  assign clear_w = instr_w && (acc_in.data == cdr_pkg::CLEAR_CODE);
  assign ac_step_w = data_wr_w || data_rd_w;

  // Pattern RAM addresses wrap within six bits
  always_comb
  begin
    ac_stepped_w = ac_q;
    if (cg_sel_q)
    begin
      if (mode_q.inc_select)
        ac_stepped_w = {1'h0, ac_q[5:0] + 6'h01};
      else
        ac_stepped_w = {1'h0, ac_q[5:0] - 6'h01};
    end
    else
    begin
      if (mode_q.inc_select)
        ac_stepped_w = ac_q + 7'h01;
      else
        ac_stepped_w = ac_q - 7'h01;
    end
  end

  // A counter read touches neither the counter nor any RAM
  always_ff @(posedge ref_clk_in)
  begin
    if (core_rst_w)
      ac_q <= cdr_pkg::AC_RESET;
    else if (clear_w || home_w)
      ac_q <= cdr_pkg::AC_RESET;
    else if (dd_set_w)
      ac_q <= acc_in.data[6:0];
    else if (cg_set_w)
      ac_q <= {1'h0, acc_in.data[5:0]};
    else if (ac_step_w)
      ac_q <= ac_stepped_w;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (core_rst_w)
      cg_sel_q <= cdr_pkg::CG_SEL_RESET;
    else if (clear_w || home_w || dd_set_w)
      cg_sel_q <= 1'h0;
    else if (cg_set_w)
      cg_sel_q <= 1'h1;
  end

  // Offset counts left shifts; only display-RAM writes step it, clear and home return it to zero
  always_ff @(posedge ref_clk_in)
  begin
    if (core_rst_w)
      offset_q <= cdr_pkg::OFFSET_RESET;
    else if (clear_w || home_w)
      offset_q <= cdr_pkg::OFFSET_RESET;
    else if (data_wr_w && !cg_sel_q && mode_q.shift_enable)
    begin
      if (mode_q.inc_select)
        offset_q <= offset_q + 7'h01;
      else
        offset_q <= offset_q - 7'h01;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (core_rst_w)
    begin
      mode_q.inc_select <= cdr_pkg::INC_RESET;
      mode_q.shift_enable <= cdr_pkg::SHIFT_RESET;
      mode_q.display_on <= cdr_pkg::DISPLAY_ON_RESET;
      mode_q.cursor_on <= cdr_pkg::CURSOR_ON_RESET;
      mode_q.blink_enable <= cdr_pkg::BLINK_RESET;
      mode_q.bus_width_select <= cdr_pkg::WIDTH8_RESET;
      mode_q.two_lines <= MULTI_LINE;
      mode_q.brightness_field <= cdr_pkg::BRIGHT_RESET;
    end
    else if (clear_w)
      mode_q.inc_select <= cdr_pkg::INC_RESET;
    else if (entry_w)
    begin
      mode_q.inc_select <= acc_in.data[cdr_pkg::ENTRY_INC_BIT];
      mode_q.shift_enable <= acc_in.data[cdr_pkg::ENTRY_SHIFT_BIT];
    end
    else if (onoff_w)
    begin
      mode_q.display_on <= acc_in.data[cdr_pkg::ONOFF_DISP_BIT];
      mode_q.cursor_on <= acc_in.data[cdr_pkg::ONOFF_CUR_BIT];
      mode_q.blink_enable <= acc_in.data[cdr_pkg::ONOFF_BLINK_BIT];
    end
    else if (fn_set_w)
    begin
      mode_q.bus_width_select <= acc_in.data[cdr_pkg::FN_WIDTH_BIT];
      mode_q.two_lines <= acc_in.data[cdr_pkg::FN_LINES_BIT];
      mode_q.brightness_field <= acc_in.data[cdr_pkg::FN_BRIGHT_MSB:cdr_pkg::FN_BRIGHT_LSB];
    end
  end

  // Display RAM: every entry is refilled with spaces by reset or clear
  genvar gi;
  generate
    for (gi = 0; gi < cdr_pkg::DDR_DEPTH; gi++)
    begin : g_ddr
      always_ff @(posedge ref_clk_in)
      begin
        if (core_rst_w || clear_w)
          ddr_q[gi] <= cdr_pkg::SPACE_CODE;
        else if (data_wr_w && !cg_sel_q && (ac_q == 7'(gi)))
          ddr_q[gi] <= acc_in.data;
      end
    end
  endgenerate

  // Pattern RAM keeps its contents over reset
  always_ff @(posedge ref_clk_in)
  begin
    if (data_wr_w && cg_sel_q)
      cgr_q[ac_q[5:0]] <= acc_in.data;
  end

  // Busy bit is a constant zero above the counter
  always_comb
  begin
    rd_value_w = {1'h0, ac_q};
    if (acc_in.cmd_data_select)
    begin
      if (cg_sel_q)
        rd_value_w = cgr_q[ac_q[5:0]];
      else
        rd_value_w = ddr_q[ac_q];
    end
  end

  assign push_w = ctr_read_w || data_rd_w;
  assign pop_w = rd_valid_out && rd_ready_in;

  always_ff @(posedge ref_clk_in)
  begin
    if (core_rst_w)
      rd_cnt_q <= 2'h0;
    else
      rd_cnt_q <= rd_cnt_q + {1'h0, push_w} - {1'h0, pop_w};
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (core_rst_w)
      rd_head_q <= 8'h00;
    else if (pop_w && (rd_cnt_q == 2'h2))
      rd_head_q <= rd_spare_q;
    else if (push_w && ((rd_cnt_q == 2'h0) || ((rd_cnt_q == 2'h1) && pop_w)))
      rd_head_q <= rd_value_w;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (core_rst_w)
      rd_spare_q <= 8'h00;
    else if (push_w && (rd_cnt_q == 2'h1) && !pop_w)
      rd_spare_q <= rd_value_w;
  end

  assign rd_valid_out = (rd_cnt_q != 2'h0);
  assign rd_data_out = rd_head_q;
  assign mode_out = mode_q;
  assign bus_mode_out = bus_mode_q;
  assign disp_offset_out = offset_q;

  sequence s_ctr_read;
    ctr_read_w && (rd_cnt_q == 2'h0);
  endsequence

  sequence s_ddr_write;
    data_wr_w && !cg_sel_q;
  endsequence

  sequence s_inc_access;
    ac_step_w && !cg_sel_q && mode_q.inc_select;
  endsequence

  sequence s_left_shift;
    data_wr_w && !cg_sel_q && mode_q.shift_enable && mode_q.inc_select;
  endsequence

  AST_CTR_READ_VALUE: assert property (@(posedge ref_clk_in) disable iff (core_rst_w)
    s_ctr_read |=> rd_data_out == {1'h0, $past(ac_q)})
    else $error("counter read returned a wrong value");

  AST_CTR_READ_KEEPS: assert property (@(posedge ref_clk_in) disable iff (core_rst_w)
    ctr_read_w |=> ac_q == $past(ac_q))
    else $error("counter read changed the counter");

  AST_NEVER_BUSY: assert property (@(posedge ref_clk_in) disable iff (core_rst_w)
    (rd_cnt_q != 2'h2) |-> acc_ready_out)
    else $error("access refused while buffer had room");

  AST_DDR_WRITE: assert property (@(posedge ref_clk_in) disable iff (core_rst_w)
    s_ddr_write |=> ddr_q[$past(ac_q)] == $past(acc_in.data))
    else $error("display write not stored");

  AST_AC_STEP: assert property (@(posedge ref_clk_in) disable iff (core_rst_w)
    s_inc_access |=> ac_q == $past(ac_q) + 7'h01)
    else $error("counter did not step after data access");

  AST_SHIFT_LEFT: assert property (@(posedge ref_clk_in) disable iff (core_rst_w)
    s_left_shift |=> offset_q == $past(offset_q) + 7'h01)
    else $error("display did not shift once");

  AST_CG_LOAD: assert property (@(posedge ref_clk_in) disable iff (core_rst_w)
    cg_set_w |=> cg_sel_q && (ac_q == {1'h0, $past(acc_in.data[5:0])}))
    else $error("pattern address set not loaded");

  AST_RESET_FILL: assert property (@(posedge ref_clk_in)
    core_rst_w |=> (ddr_q[0] == cdr_pkg::SPACE_CODE) && (ddr_q[127] == cdr_pkg::SPACE_CODE))
    else $error("display RAM not filled on reset");

  AST_RESET_AC: assert property (@(posedge ref_clk_in)
    core_rst_w |=> (ac_q == cdr_pkg::AC_RESET) && !cg_sel_q && (offset_q == cdr_pkg::OFFSET_RESET))
    else $error("counter or offset not reset");

  AST_RESET_MODE: assert property (@(posedge ref_clk_in)
    core_rst_w |=> mode_q.inc_select && !mode_q.shift_enable && !mode_q.display_on
      && mode_q.bus_width_select && (mode_q.brightness_field == cdr_pkg::BRIGHT_RESET))
    else $error("mode bits not reset");

endmodule // cdr_core

/* test/cdr_host.sv */
// Host-side receiver of read data, able to stall
`timescale 1ns/1ps
module cdr_host (
  input wire logic stall_in,
  output logic rd_ready_out
);
  assign rd_ready_out = !stall_in;
endmodule // cdr_host

/* test/cdr_core_tb.sv */
// Testbench for the display data access core
`timescale 1ns/1ps
module cdr_core_tb;
  logic ref_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic acc_valid_in = 1'h0;
  logic stall = 1'h0;
  logic ext_n = 1'h1;
  logic str_sa = 1'h0;
  logic str_sb = 1'h0;
  logic str_en = 1'h0;
  logic str_st = 1'h1;
  logic str_rpe = 1'h1;
  logic rd_ready;
  logic rd_valid;
  logic acc_ready;
  logic [7:0] rd_data;
  logic [7:0] q;
  logic [6:0] offset;
  cdr_pkg::cdr_mode_s mode;
  cdr_pkg::cdr_bus_mode_e bus_mode;
  cdr_pkg::cdr_access_s acc = '0;
  int error_cnt = 0;
  int n_tests = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  cdr_host host (.stall_in(stall), .rd_ready_out(rd_ready));
  cdr_core dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .strap_serial_a_in(str_sa),
    .strap_serial_b_in(str_sb), .strap_enable_style_bus_in(str_en),
    .strap_strobe_style_bus_in(str_st), .strap_reset_pin_enable_in(str_rpe),
    .ext_reset_n_in(ext_n), .acc_valid_in(acc_valid_in), .acc_ready_out(acc_ready),
    .acc_in(acc), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready), .rd_data_out(rd_data),
    .mode_out(mode), .bus_mode_out(bus_mode), .disp_offset_out(offset));
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t mismatch seen %0h expected %0h", $time, s, e);
    end
  endtask
  // Request stands from just after an edge until the edge that samples ready high
  task automatic send(input logic c, input logic r, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    acc = '{c, r, d};
    acc_valid_in = 1'h1;
    do @(posedge ref_clk_in); while (acc_ready !== 1'h1);
    #1;
    acc_valid_in = 1'h0;
  endtask
  task automatic take;
    do @(posedge ref_clk_in); while (!(rd_valid === 1'h1 && rd_ready === 1'h1));
    q = rd_data;
  endtask
  task automatic op(input logic c, input logic r, input logic [7:0] d);
    send(c, r, d);
    if (r)
      take;
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task stop_test;
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset;
    chk(mode.inc_select, 1'h1);
    chk(mode.shift_enable, 1'h0);
    chk(mode.display_on, 1'h0);
    chk(mode.cursor_on, 1'h0);
    chk(mode.blink_enable, 1'h0);
    chk(mode.bus_width_select, 1'h1);
    chk(mode.two_lines, 1'h1);
    chk(mode.brightness_field, 2'h0);
    chk(offset, 7'h00);
    op(1'h0, 1'h0, 8'h38);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h00);
  endtask
  task automatic t_write;
    op(1'h1, 1'h0, 8'h41);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h01);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h01);
    chk(q[7], 1'h0);
  endtask
  task automatic t_read;
    op(1'h0, 1'h0, 8'h80);
    op(1'h1, 1'h1, 8'h00);
    chk(q, 8'h41);
    op(1'h1, 1'h1, 8'h00);
    chk(q, 8'h20);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h02);
  endtask
  task automatic t_char_pattern_ram;
    op(1'h0, 1'h0, 8'h45);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h05);
    op(1'h1, 1'h0, 8'h1f);
    op(1'h1, 1'h0, 8'h0e);
    op(1'h0, 1'h0, 8'h45);
    op(1'h1, 1'h1, 8'h00);
    chk(q, 8'h1f);
    op(1'h1, 1'h1, 8'h00);
    chk(q, 8'h0e);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h07);
    op(1'h0, 1'h0, 8'h80);
    op(1'h1, 1'h1, 8'h00);
    chk(q, 8'h41);
  endtask
  task automatic t_shift;
    op(1'h0, 1'h0, 8'h07);
    op(1'h0, 1'h0, 8'h90);
    op(1'h1, 1'h0, 8'h42);
    chk(offset, 7'h01);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h11);
    op(1'h0, 1'h0, 8'h90);
    op(1'h1, 1'h1, 8'h00);
    chk(q, 8'h42);
    chk(offset, 7'h01);
    op(1'h0, 1'h0, 8'h05);
    chk(mode.inc_select, 1'h0);
    op(1'h0, 1'h0, 8'h90);
    op(1'h1, 1'h0, 8'h43);
    chk(offset, 7'h00);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h0f);
    op(1'h0, 1'h0, 8'h06);
  endtask
  task automatic t_modes;
    op(1'h0, 1'h0, 8'h0f);
    chk(mode.display_on, 1'h1);
    chk(mode.cursor_on, 1'h1);
    chk(mode.blink_enable, 1'h1);
    op(1'h0, 1'h0, 8'h3b);
    chk(mode.brightness_field, 2'h3);
    op(1'h0, 1'h0, 8'h31);
    chk(mode.brightness_field, 2'h1);
    op(1'h0, 1'h0, 8'h22);
    chk(mode.brightness_field, 2'h2);
    chk(mode.bus_width_select, 1'h0);
    chk(mode.two_lines, 1'h0);
  endtask
  task automatic t_stall;
    op(1'h0, 1'h0, 8'ha0);
    stall = 1'h1;
    send(1'h0, 1'h1, 8'h00);
    send(1'h1, 1'h0, 8'h55);
    send(1'h0, 1'h1, 8'h00);
    chk(rd_valid, 1'h1);
    chk(acc_ready, 1'h0);
    send(1'h0, 1'h0, 8'h06);
    chk(acc_ready, 1'h1);
    stall = 1'h0;
    take;
    chk(q, 8'h20);
    take;
    chk(q, 8'h21);
  endtask
  task automatic t_straps;
    str_sa = 1'h1;
    str_sb = 1'h1;
    wait_cycles(4);
    chk(bus_mode, cdr_pkg::CDR_BUS_SERIAL);
    str_sa = 1'h0;
    str_sb = 1'h0;
    str_en = 1'h1;
    str_st = 1'h0;
    wait_cycles(4);
    chk(bus_mode, cdr_pkg::CDR_BUS_ENABLE);
    str_en = 1'h0;
    str_st = 1'h1;
    wait_cycles(4);
    chk(bus_mode, cdr_pkg::CDR_BUS_STROBE);
  endtask
  task automatic t_ext_reset;
    op(1'h0, 1'h0, 8'h3b);
    str_rpe = 1'h0;
    wait_cycles(3);
    ext_n = 1'h0;
    wait_cycles(4);
    chk(mode.brightness_field, 2'h3);
    ext_n = 1'h1;
    str_rpe = 1'h1;
    wait_cycles(3);
    ext_n = 1'h0;
    wait_cycles(4);
    ext_n = 1'h1;
    wait_cycles(3);
    chk(mode.brightness_field, 2'h0);
    chk(mode.inc_select, 1'h1);
    op(1'h0, 1'h0, 8'h38);
    op(1'h0, 1'h0, 8'h06);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h00);
    op(1'h1, 1'h1, 8'h00);
    chk(q, 8'h20);
  endtask
  task automatic t_pin_reset;
    op(1'h0, 1'h0, 8'h3b);
    rst_n_in = 1'h0;
    wait_cycles(2);
    rst_n_in = 1'h1;
    chk(mode.brightness_field, 2'h0);
    chk(offset, 7'h00);
    op(1'h0, 1'h0, 8'h38);
    op(1'h0, 1'h1, 8'h00);
    chk(q, 8'h00);
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    #81;
    rst_n_in = 1'h1;
    t_reset;
    t_write;
    t_read;
    t_char_pattern_ram;
    t_shift;
    t_modes;
    t_stall;
    t_straps;
    t_ext_reset;
    t_pin_reset;
    stop_test;
  end
endmodule // cdr_core_tb
